/* design/adi_top.sv */
// adi_top: APB register file and event logic for accessory detection on the
// two bias sources. detect inputs come from analog comparators, synchronous
// to pclk. debounce_tick_clock arrives as a synchronous level and is edge
// detected here; without it a debounced input never updates.
`timescale 1ns/100ps
// Contract
// - two thresholds shared by both bias sources
// - detect levels go to pin and events
// - each input has debounce and polarity
// - status bits latch until cleared, pollable
// - latched status feeds combined interrupt output
// - write one clears status, zero keeps
// - power bits 5/4 enable bias two/one
// - bias bits 7:6 select short threshold
// - bias bits 5:4 select detect threshold
// - bias bit 2 enables detect function
// - bias bits 1/0 set bias levels
// - status bits 15,14,10,9 hold events
// - debounce enables at bits 15,14,10,9
// - mask bits 13/12 for bias two
// - mask bits 10/9 for bias one
// - polarity bits select active level
// - pin select 8..B outputs raw detect
module adi_top
  import adi_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // raw detect levels from comparators
  input  wire logic        bias_one_detect,
  input  wire logic        bias_one_short,
  input  wire logic        bias_two_detect,
  input  wire logic        bias_two_short,
  input  wire logic        debounce_tick_clock,
  // analog controls
  output logic             bias_one_on,
  output logic             bias_two_on,
  output logic             bias_one_level,
  output logic             bias_two_level,
  output logic [1:0]       short_threshold_sel,
  output logic [1:0]       detect_threshold_sel,
  output logic             detect_function_on,
  // interrupt and pin
  output logic             irq,
  output logic             general_pin_one,
  output logic             general_pin_one_oe
);

  logic [15:0] power_control_one;
  logic [15:0] event_status;
  logic [15:0] event_debounce_enable;
  logic [15:0] event_mask;
  logic [15:0] event_polarity;
  logic [15:0] bias_detect_config;
  logic [3:0]  general_pin_function;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [7:0]  idx;
  logic [15:0] wdata16;
  logic [15:0] next_rdata;
  logic        tick_d;
  logic        tick;
  logic [3:0]  raw_ev;
  logic [3:0]  qual_ev;
  logic [3:0]  qual_d;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;

  // event index to status bit position
  function automatic int ev_pos(input int ev);
    case (ev)
      ADI_EV_ONE_DETECT: ev_pos = ADI_POS_ONE_DETECT;
      ADI_EV_ONE_SHORT:  ev_pos = ADI_POS_ONE_SHORT;
      ADI_EV_TWO_DETECT: ev_pos = ADI_POS_TWO_DETECT;
      default:           ev_pos = ADI_POS_TWO_SHORT;
    endcase
  endfunction : ev_pos

  // 16-bit register write honouring the two low byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] cur, input logic [15:0] wd,
                                          input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : cur[15:8], st[0] ? wd[7:0] : cur[7:0]};
  endfunction : merge16

  // apb decode; zero wait states
  assign idx     = paddr[9:2];
  assign wdata16 = pwdata[15:0];
  assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                   (idx == ADI_IDX_POWER_ONE || idx == ADI_IDX_STATUS ||
                    idx == ADI_IDX_DEBOUNCE || idx == ADI_IDX_MASK ||
                    idx == ADI_IDX_POLARITY || idx == ADI_IDX_BIAS ||
                    idx == ADI_IDX_PIN_SEL);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_control_one     <= ADI_RST_REG;
      event_debounce_enable <= ADI_RST_REG;
      event_mask            <= ADI_RST_REG;
      event_polarity        <= ADI_RST_REG;
      bias_detect_config    <= ADI_RST_REG;
      general_pin_function  <= 4'h0;
    end
    else if (wr_en)
    begin
      unique case (idx)
        ADI_IDX_POWER_ONE: power_control_one     <= merge16(power_control_one, wdata16, pstrb);
        ADI_IDX_DEBOUNCE:  event_debounce_enable <= merge16(event_debounce_enable, wdata16, pstrb);
        ADI_IDX_MASK:      event_mask            <= merge16(event_mask, wdata16, pstrb);
        ADI_IDX_POLARITY:  event_polarity        <= merge16(event_polarity, wdata16, pstrb);
        ADI_IDX_BIAS:      bias_detect_config    <= merge16(bias_detect_config, wdata16, pstrb);
        ADI_IDX_PIN_SEL:
        begin
          if (pstrb[0])
            general_pin_function <= wdata16[3:0];
        end
        default: ;
      endcase
    end
  end

  // analog control outputs
  assign bias_two_on          = power_control_one[ADI_POS_BIAS_TWO_ON];
  assign bias_one_on          = power_control_one[ADI_POS_BIAS_ONE_ON];
  assign short_threshold_sel  = bias_detect_config[ADI_POS_SHORT_THR +: 2];
  assign detect_threshold_sel = bias_detect_config[ADI_POS_DETECT_THR +: 2];
  assign detect_function_on   = bias_detect_config[ADI_POS_DETECT_ON];
  assign bias_two_level       = bias_detect_config[ADI_POS_BIAS_TWO_LVL];
  assign bias_one_level       = bias_detect_config[ADI_POS_BIAS_ONE_LVL];

  // timeout clock sampled as a level; one tick per rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_d <= 1'b0;
    else
      tick_d <= debounce_tick_clock;
  end
  assign tick = debounce_tick_clock && !tick_d;

  // comparators only count while the detect function is on
  assign raw_ev[ADI_EV_ONE_DETECT] = bias_one_detect && detect_function_on;
  assign raw_ev[ADI_EV_ONE_SHORT]  = bias_one_short && detect_function_on;
  assign raw_ev[ADI_EV_TWO_DETECT] = bias_two_detect && detect_function_on;
  assign raw_ev[ADI_EV_TWO_SHORT]  = bias_two_short && detect_function_on;

  for (genvar g = 0; g < ADI_EV_N; g++)
  begin : g_ev
    adi_debounce u_db (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (tick),
      .filter_on (event_debounce_enable[ev_pos(g)]),
      .sense_low (event_polarity[ev_pos(g)]),
      .raw       (raw_ev[g]),
      .level     (qual_ev[g])
    );
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      qual_d <= 4'h0;
    else
      qual_d <= qual_ev;
  end

  // set and clear vectors in status bit positions
  always_comb
  begin
    set_vec = 16'h0000;
    for (int e = 0; e < ADI_EV_N; e++)
      set_vec[ev_pos(e)] = qual_ev[e] && !qual_d[e];
    clr_vec = 16'h0000;
    if (wr_en && idx == ADI_IDX_STATUS)
      clr_vec = {pstrb[1] ? wdata16[15:8] : 8'h00, pstrb[0] ? wdata16[7:0] : 8'h00};
  end

  // latched status; set wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_status <= ADI_RST_REG;
    else
      event_status <= (event_status & ~clr_vec) | set_vec;
  end

  // combined interrupt; mask positions differ from status for bias two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= (event_status[ADI_POS_TWO_DETECT] && !event_mask[ADI_MPOS_TWO_DETECT]) ||
             (event_status[ADI_POS_TWO_SHORT] && !event_mask[ADI_MPOS_TWO_SHORT]) ||
             (event_status[ADI_POS_ONE_SHORT] && !event_mask[ADI_MPOS_ONE_SHORT]) ||
             (event_status[ADI_POS_ONE_DETECT] && !event_mask[ADI_MPOS_ONE_DETECT]);
  end

  // general pin shows the comparator level, polarity ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      general_pin_one    <= 1'b0;
      general_pin_one_oe <= 1'b0;
    end
    else
    begin
      general_pin_one_oe <= general_pin_function[3:2] == 2'b10;
      unique case (general_pin_function)
        ADI_SEL_ONE_DETECT: general_pin_one <= raw_ev[ADI_EV_ONE_DETECT];
        ADI_SEL_ONE_SHORT:  general_pin_one <= raw_ev[ADI_EV_ONE_SHORT];
        ADI_SEL_TWO_DETECT: general_pin_one <= raw_ev[ADI_EV_TWO_DETECT];
        ADI_SEL_TWO_SHORT:  general_pin_one <= raw_ev[ADI_EV_TWO_SHORT];
        default:            general_pin_one <= 1'b0;
      endcase
    end
  end

  // read mux; data registered in the setup phase
  always_comb
  begin
    next_rdata = 16'h0000;
    unique case (idx)
      ADI_IDX_POWER_ONE: next_rdata = power_control_one;
      ADI_IDX_STATUS:    next_rdata = event_status;
      ADI_IDX_DEBOUNCE:  next_rdata = event_debounce_enable;
      ADI_IDX_MASK:      next_rdata = event_mask;
      ADI_IDX_POLARITY:  next_rdata = event_polarity;
      ADI_IDX_BIAS:      next_rdata = bias_detect_config;
      ADI_IDX_PIN_SEL:   next_rdata = {12'h000, general_pin_function};
      default:           next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= addr_ok ? {16'h0000, next_rdata} : 32'h0000_0000;
  end

endmodule : adi_top

/* design/adi_pkg.sv */
// adi_pkg: register map, field positions, reset values and debounce timing
// for the accessory detection interrupt block.
// assumes APB with 32-bit data; printed offsets are register indices.
package adi_pkg;

  // register indices as printed; byte address is index times four
  localparam logic [7:0] ADI_IDX_POWER_ONE = 8'h01;
  localparam logic [7:0] ADI_IDX_STATUS    = 8'h12;
  localparam logic [7:0] ADI_IDX_DEBOUNCE  = 8'h14;
  localparam logic [7:0] ADI_IDX_MASK      = 8'h16;
  localparam logic [7:0] ADI_IDX_POLARITY  = 8'h17;
  localparam logic [7:0] ADI_IDX_BIAS      = 8'h3A;
  localparam logic [7:0] ADI_IDX_PIN_SEL   = 8'h13;

  // power control one fields
  localparam int ADI_POS_BIAS_TWO_ON = 5;
  localparam int ADI_POS_BIAS_ONE_ON = 4;

  // bias_detect_config fields
  localparam int ADI_POS_SHORT_THR = 6;
  localparam int ADI_POS_DETECT_THR = 4;
  localparam int ADI_POS_DETECT_ON = 2;
  localparam int ADI_POS_BIAS_TWO_LVL = 1;
  localparam int ADI_POS_BIAS_ONE_LVL = 0;

  // event bit positions, shared by status, debounce and polarity
  localparam int ADI_POS_TWO_SHORT  = 15;
  localparam int ADI_POS_TWO_DETECT = 14;
  localparam int ADI_POS_ONE_SHORT  = 10;
  localparam int ADI_POS_ONE_DETECT = 9;

  // mask register positions differ for bias two
  localparam int ADI_MPOS_TWO_DETECT = 13;
  localparam int ADI_MPOS_TWO_SHORT  = 12;
  localparam int ADI_MPOS_ONE_SHORT  = 10;
  localparam int ADI_MPOS_ONE_DETECT = 9;

  // general pin function select field width and detect codes
  localparam int         ADI_SEL_W          = 4;
  localparam logic [3:0] ADI_SEL_ONE_DETECT = 4'h8;
  localparam logic [3:0] ADI_SEL_ONE_SHORT  = 4'h9;
  localparam logic [3:0] ADI_SEL_TWO_DETECT = 4'hA;
  localparam logic [3:0] ADI_SEL_TWO_SHORT  = 4'hB;

  localparam logic [15:0] ADI_RST_REG = 16'h0000;

  // stable level must persist this many timeout ticks
  localparam int          ADI_DB_TICKS   = 4;
  localparam logic [2:0]  ADI_DB_TICKS_3 = 3'(ADI_DB_TICKS);

  // event index order used internally
  localparam int ADI_EV_ONE_DETECT = 0;
  localparam int ADI_EV_ONE_SHORT  = 1;
  localparam int ADI_EV_TWO_DETECT = 2;
  localparam int ADI_EV_TWO_SHORT  = 3;
  localparam int ADI_EV_N          = 4;

endpackage : adi_pkg

/* design/adi_debounce.sv */
// adi_debounce: one detect input, polarity applied, optional debounce.
// assumes tick is a one-cycle pulse in the pclk domain from the timeout clock.
`timescale 1ns/100ps
module adi_debounce
  import adi_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic tick,
  input  wire logic filter_on,
  input  wire logic sense_low,
  // detect level in, qualified level out
  input  wire logic raw,
  output logic      level
);

  logic       adjusted;
  logic       stable;
  logic [2:0] count;

  assign adjusted = raw ^ sense_low;

  // candidate level and the ticks it has held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stable <= 1'b0;
      count  <= 3'h0;
    end
    else if (adjusted != stable)
    begin
      stable <= adjusted;
      count  <= 3'h0;
    end
    else if (tick && count != ADI_DB_TICKS_3)
    begin
      count <= count + 3'h1;
    end
  end

  // filtered output follows only once stable long enough
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level <= 1'b0;
    else if (!filter_on)
      level <= adjusted;
    else if (adjusted == stable && count == ADI_DB_TICKS_3)
      level <= stable;
  end

endmodule : adi_debounce

/* dv/adi_monitor.sv */
// adi_monitor: concurrent checks on the ports of adi_top
// assumes zero wait apb writes with all byte strobes set
`timescale 1ns/100ps
module adi_monitor
  import adi_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // detect and controls
  input wire logic        bias_one_detect,
  input wire logic        bias_one_on,
  input wire logic        bias_two_on,
  input wire logic        bias_one_level,
  input wire logic        bias_two_level,
  input wire logic [1:0]  short_threshold_sel,
  input wire logic [1:0]  detect_threshold_sel,
  input wire logic        detect_function_on,
  // interrupt and pin
  input wire logic        irq,
  input wire logic        general_pin_one,
  input wire logic        general_pin_one_oe
);
  logic       wr;
  logic       chg;
  logic [5:0] trk;
  logic [5:0] next_trk;

  function automatic logic at(input logic [11:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction : at

  assign wr = psel && penable && pwrite && pready;
  // a mask write or a nonzero status write may lower irq; nothing else may
  assign chg = wr && (at(paddr, ADI_IDX_MASK) || (at(paddr, ADI_IDX_STATUS) && |pwdata[15:0]));
  // mask bits 13,12,10,9 then debounce and polarity of bias one detect
  assign next_trk = {at(paddr, ADI_IDX_MASK) ? {pwdata[13:12], pwdata[10:9]} : trk[5:2],
                     at(paddr, ADI_IDX_DEBOUNCE) ? pwdata[9] : trk[1],
                     at(paddr, ADI_IDX_POLARITY) ? pwdata[9] : trk[0]};

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      trk <= '0;
    else if (wr)
      trk <= next_trk;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bias_on: assert property (wr && at(paddr, ADI_IDX_POWER_ONE) |=> {bias_two_on, bias_one_on} == $past(pwdata[5:4]))
    else $error("bias enables differ from write");
  a_threshold_fields: assert property (wr && at(paddr, ADI_IDX_BIAS) |=> {short_threshold_sel, detect_threshold_sel} == $past(pwdata[7:4]))
    else $error("thresholds differ from write");
  a_detect_ctl: assert property (wr && at(paddr, ADI_IDX_BIAS) |=> {detect_function_on, bias_two_level, bias_one_level} == $past(pwdata[2:0]))
    else $error("detect enable or levels differ");
  a_cfg_hold: assert property (!(wr && at(paddr, ADI_IDX_BIAS)) |=> $stable({short_threshold_sel, detect_threshold_sel}))
    else $error("thresholds moved without write");
  a_irq_event: assert property ($rose(bias_one_detect) && detect_function_on && !(|trk[2:0]) |-> ##[1:4] irq)
    else $error("detect rise gave no irq");
  a_irq_masked: assert property (&trk[5:2] && $past(&trk[5:2]) |-> !irq)
    else $error("irq with all events masked");
  a_status_hold: assert property (irq && !chg && !$past(chg) |=> irq)
    else $error("irq dropped without clear");
  a_pin_quiet: assert property (!general_pin_one_oe |-> !general_pin_one)
    else $error("pin high while not driven");

  c_irq: cover property ($rose(irq));
  c_pin: cover property (general_pin_one_oe && general_pin_one);
  c_zero_write: cover property (irq && wr && at(paddr, ADI_IDX_STATUS) && pwdata == '0);
endmodule : adi_monitor

bind adi_top adi_monitor u_adi_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
  .bias_one_detect, .bias_one_on, .bias_two_on, .bias_one_level, .bias_two_level, .short_threshold_sel,
  .detect_threshold_sel, .detect_function_on, .irq, .general_pin_one, .general_pin_one_oe);

/* dv/adi_accessory.sv */
// adi_accessory: accessory load on both bias outputs with its comparators
// assumes load codes where code n draws 75uA shifted left by n, 0 is none
`timescale 1ns/100ps
module adi_accessory
  import adi_pkg::*;
(
  // clock
  input  wire logic       pclk,
  // bias and shared thresholds
  input  wire logic       bias_one_on,
  input  wire logic       bias_two_on,
  input  wire logic [1:0] short_threshold_sel,
  input  wire logic [1:0] detect_threshold_sel,
  // load codes
  input  wire logic [2:0] load_one,
  input  wire logic [2:0] load_two,
  // comparator levels
  output logic            bias_one_detect,
  output logic            bias_one_short,
  output logic            bias_two_detect,
  output logic            bias_two_short
);
  // a source that is off draws no current, so its comparators stay low
  always_ff @(posedge pclk)
  begin
    bias_one_detect <= bias_one_on && load_one > 3'(detect_threshold_sel) + 3'd1;
    bias_one_short  <= bias_one_on && load_one > 3'(short_threshold_sel) + 3'd2;
    bias_two_detect <= bias_two_on && load_two > 3'(detect_threshold_sel) + 3'd1;
    bias_two_short  <= bias_two_on && load_two > 3'(short_threshold_sel) + 3'd2;
  end
endmodule : adi_accessory

/* dv/test_adi_top.sv */
// test_adi_top: registers, events, mask, polarity, debounce and pin select
// assumes zero wait apb and the accessory model on the detect inputs
`timescale 1ns/100ps
module test_adi_top
  import adi_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, debounce_tick_clock = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, seed = 32'h17, d, prdata;
  logic [2:0]  load_one = '0, load_two = '0;
  logic [1:0]  short_threshold_sel, detect_threshold_sel;
  logic        pready, pslverr, irq, general_pin_one, general_pin_one_oe, detect_function_on;
  logic        bias_one_on, bias_two_on, bias_one_level, bias_two_level;
  logic        bias_one_detect, bias_one_short, bias_two_detect, bias_two_short;
  logic [32:0] expq[$];
  int          num_errors = 0, comparisons = 0;
  logic [7:0]  ridx[7] = '{ADI_IDX_POWER_ONE, ADI_IDX_STATUS, ADI_IDX_DEBOUNCE, ADI_IDX_MASK, ADI_IDX_POLARITY,
                          ADI_IDX_BIAS, ADI_IDX_PIN_SEL};
  logic [2:0]  lo[4] = '{3'd2, 3'd4, 3'd0, 3'd0}, lt[4] = '{3'd0, 3'd0, 3'd2, 3'd4};
  logic [15:0] st[4] = '{16'h0200, 16'h0600, 16'h4000, 16'hC000};
  logic [3:0]  fsel[5] = '{ADI_SEL_ONE_DETECT, ADI_SEL_ONE_SHORT, ADI_SEL_TWO_DETECT, ADI_SEL_TWO_SHORT, 4'h0};
  logic [1:0]  pexp[5] = '{2'b11, 2'b11, 2'b11, 2'b10, 2'b00};

  always #5 pclk = ~pclk;

  adi_top u_adi_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
    .pslverr, .bias_one_detect, .bias_one_short, .bias_two_detect, .bias_two_short, .debounce_tick_clock,
    .bias_one_on, .bias_two_on, .bias_one_level, .bias_two_level, .short_threshold_sel, .detect_threshold_sel,
    .detect_function_on, .irq, .general_pin_one, .general_pin_one_oe);
  adi_accessory u_adi_accessory (.pclk, .bias_one_on, .bias_two_on, .short_threshold_sel, .detect_threshold_sel,
    .load_one, .load_two, .bias_one_detect, .bias_one_short, .bias_two_detect, .bias_two_short);

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] v);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 50);
    if (n == 50)
    begin
      num_errors++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v);
  endtask : wr

  // the read monitor pops this note when the access phase completes
  task automatic rd(input logic [7:0] idx, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, idx, '0);
  endtask : rd

  task automatic wait_irq();
    int n;
    for (n = 0; n < 20 && irq !== 1'b1; n++)
      @(posedge pclk);
    check(33'(irq), 33'h1);
    if (n == 20)
      summarize();
  endtask : wait_irq

  // slow timeout clock, only run while a filtered input must settle
  task automatic ticks(input int k);
    repeat (k)
    begin
      repeat (3) @(posedge pclk);
      debounce_tick_clock <= 1'b1;
      repeat (3) @(posedge pclk);
      debounce_tick_clock <= 1'b0;
    end
  endtask : ticks

  always @(posedge pclk)
    if (psel && penable && !pwrite && pready)
      check({pslverr, prdata}, expq.pop_front());

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ridx[i])
      rd(ridx[i], '0);
    rd(8'h02, {1'b1, 32'h0});
    $display("reset values done");
    for (int i = 0; i < 4; i++)
    begin
      d = rnd() & 32'hF7;
      d[7:4] = {i[1:0], ~i[1:0]};
      wr(ADI_IDX_BIAS, d);
      wr(ADI_IDX_POWER_ONE, d & 32'h30);
      @(negedge pclk);
      check(33'({short_threshold_sel, detect_threshold_sel, detect_function_on, bias_two_level, bias_one_level}),
            33'({d[7:4], d[2:0]}));
      check(33'({bias_two_on, bias_one_on}), 33'(d[5:4]));
      rd(ADI_IDX_BIAS, {1'b0, d});
    end
    $display("configuration done");
    wr(ADI_IDX_POWER_ONE, 32'h30);
    wr(ADI_IDX_BIAS, 32'h04);
    for (int i = 0; i < 4; i++)
    begin
      load_one <= lo[i];
      load_two <= lt[i];
      wait_irq();
      load_one <= '0;
      load_two <= '0;
      wr(ADI_IDX_STATUS, 32'h0);
      rd(ADI_IDX_STATUS, {17'h0, st[i]});
      wr(ADI_IDX_STATUS, {16'h0, st[i]});
      rd(ADI_IDX_STATUS, '0);
      check(33'(irq), '0);
    end
    $display("events done");
    wr(ADI_IDX_MASK, 32'h3600);
    load_one <= 3'd4;
    load_two <= 3'd4;
    repeat (10) @(posedge pclk);
    check(33'(irq), '0);
    rd(ADI_IDX_STATUS, 33'h0C600);
    wr(ADI_IDX_MASK, 32'h0);
    wait_irq();
    wr(ADI_IDX_STATUS, 32'hC600);
    $display("mask done");
    load_one <= '0;
    load_two <= '0;
    wr(ADI_IDX_POLARITY, 32'h0200);
    repeat (6) @(posedge pclk);
    wr(ADI_IDX_STATUS, 32'hFFFF);
    load_one <= 3'd2;
    repeat (10) @(posedge pclk);
    rd(ADI_IDX_STATUS, '0);
    load_one <= '0;
    wait_irq();
    rd(ADI_IDX_STATUS, 33'h00200);
    wr(ADI_IDX_STATUS, 32'hFFFF);
    $display("polarity done");
    wr(ADI_IDX_DEBOUNCE, 32'h4000);
    load_two <= 3'd2;
    ticks(3);
    rd(ADI_IDX_STATUS, '0);
    // the fourth tick is the first one allowed to pass the level through
    ticks(1);
    rd(ADI_IDX_STATUS, 33'h04000);
    $display("debounce done");
    wr(ADI_IDX_POLARITY, 32'hC600);
    load_one <= 3'd4;
    for (int i = 0; i < 5; i++)
    begin
      wr(ADI_IDX_PIN_SEL, 32'(fsel[i]));
      repeat (3) @(posedge pclk);
      check(33'({general_pin_one_oe, general_pin_one}), 33'(pexp[i]));
    end
    $display("pin select done");
    check(33'(expq.size()), '0);
    summarize();
  end
endmodule : test_adi_top
